// *** link_ctrl_model.sv ***
`default_nettype none
module link_ctrl_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // link pins
  output var  logic       req_line,
  output var  logic [1:0] lines_in,
  input  wire logic [1:0] lines_out,
  input  wire logic       lines_oe_n,
  input  wire logic [1:0] dat
);
  timeunit 1ns;
  timeprecision 1ps;
  int          hold = 4;
  int          own;
  int          ns;
  logic [3:0]  idx;
  logic [3:0]  nlen;
  logic [15:0] cap;
  logic [15:0] word;

  initial req_line = 1'b0;

  // serial request, first bit on the line is v[n-1]
  // every stream ends low, so the line rests low after its last bit
  task automatic send(input logic [16:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      req_line <= v[i];
      @(posedge clk);
    end
  endtask

  // ************
  // owned control lines; hold of 1 is a cancelled ack on a bad header
  // ************
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      own      <= 0;
      lines_in <= 2'h0;
    end
    else if (lines_out == 2'h3 && !lines_oe_n)
    begin
      own      <= hold;
      lines_in <= 2'h2;
    end
    else if (own > 1)
    begin
      own      <= own - 1;
      lines_in <= 2'h2;
    end
    else if (own == 1)
    begin
      own      <= 0;
      lines_in <= 2'h0;
    end
    else
      lines_in <= ~lines_in;

  // status capture, a cut register byte is dropped
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      idx  <= 4'h0;
      ns   <= 0;
      cap  <= 16'h0000;
      nlen <= 4'h0;
      word <= 16'h0000;
    end
    else if (lines_out == 2'h1 && !lines_oe_n)
    begin
      cap[{idx, 1'b0} +: 2] <= dat;
      idx                   <= idx + 4'h1;
    end
    else if (idx != 4'h0)
    begin
      nlen <= idx;
      word <= (idx < 4'h8) ? {12'h000, cap[3:0]} : cap;
      cap  <= 16'h0000;
      idx  <= 4'h0;
      ns   <= ns + 1;
    end
endmodule
`default_nettype wire

// *** link_phy_port.sv ***
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`default_nettype none
// How it works
// R1 - link requests immediately while its packet arrives
// R2 - pending immediate request granted when packet ends
// R3 - link drops a grant on bad header
// R4 - link keeps one bus request outstanding
// R5 - new bus request ignored while one pends
// R6 - bus reset clears every pending bus request
// R7 - register write lands when request completes
// R8 - register read answered by status, retried
// R9 - further reads ignored while owed; survives reset
// R10 - enable bit in register five enables acceleration
// R11 - acceleration request switches acceleration at once
// R12 - bus reset or iso request re-enables acceleration
// R13 - link toggles acceleration around cycle start
// R14 - status starts only when owed and idle
// R15 - status holds code 01, bits on lines
// R16 - packet arrival cuts status, retried later
// R17 - one idle cycle between status transfers
// R18 - four flags normally, sixteen bits with register
// R19 - node id register sent after self id
// R20 - flags delivered when driven, register when complete
// R21 - retry only while something is still owed
// R22 - flags: reset gap, subaction gap, reset, irq
// R23 - read request: start, 100, address, stop
// R24 - write request: start, 101, address, data, stop
// R25 - acceleration request: start, 110, control, stop
// R26 - status shifted two bits a cycle, ascending
// R27 - link samples data lines during status
module link_phy_port
  import lrs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // avalon-mm register slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // link pins
  input  wire logic        link_request_line,
  input  wire logic [1:0]  interface_control_lines_in,
  output logic      [1:0]  interface_control_lines_out,
  output logic             interface_control_lines_oe_n,
  output logic      [1:0]  data_out,
  output logic             data_oe_n,
  // arbitration core
  input  wire logic        pkt_rx,
  input  wire logic        arb_won,
  input  wire logic        bus_reset,
  input  wire logic        arb_reset_gap,
  input  wire logic        subaction_gap,
  input  wire logic        self_id_done,
  input  wire logic        core_irq,
  output logic             req_pending,
  output logic      [2:0]  req_kind,
  output logic             accel_en
);

  typedef enum logic [2:0] {s_idle, s_stat, s_recv, s_grant, s_link}
    line_state_t;

  function automatic logic [1:0] pick2(input logic [15:0] f,
                                       input logic [4:0] i);
    logic [15:0] s;
    s = f >> i;
    return s[1:0];
  endfunction

  req_if    req ();
  regmem_if rm ();

  req_rx u_rx (
    .clk               (clk),
    .arst_n            (arst_n),
    .link_request_line (link_request_line),
    .req               (req)
  );

  reg_mem u_mem (
    .clk    (clk),
    .arst_n (arst_n),
    .port   (rm)
  );

  // ****************************************************************
  // bus requests and acceleration
  // ****************************************************************
  logic       pend_q, pend_d;
  logic [2:0] kind_q, kind_d;
  logic       acc_on_q, acc_on_d;
  logic       acc_bit_q, acc_bit_d;
  logic       new_bus;
  logic       grant_go;

  always_comb
  begin
    pend_d    = pend_q;
    kind_d    = kind_q;
    acc_on_d  = acc_on_q;
    acc_bit_d = acc_bit_q;
    new_bus   = req.valid && is_bus(req.kind);
    // fair and priority are dropped while a packet arrives
    if (new_bus && !pend_q && !(pkt_rx && is_async(req.kind)))
    begin
      pend_d = 1'b1; // R5
      kind_d = req.kind;
    end
    if (req.valid && req.kind == REQ_ACC)
      acc_on_d = req.accel_on; // R11
    if (new_bus && req.kind == REQ_ISO)
      acc_on_d = 1'b1; // R12
    if (req.valid && req.kind == REQ_WR && req.addr == REG_ACCEL)
      acc_bit_d = req.data[ACCEL_EN_BIT]; // R10
    if (grant_go || (pkt_rx && pend_q && is_async(kind_q)))
      pend_d = 1'b0;
    if (bus_reset)
    begin
      pend_d   = 1'b0; // R6
      acc_on_d = 1'b1; // R12
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q    <= 1'b0;
      kind_q    <= 3'h0;
      acc_on_q  <= 1'b1;
      acc_bit_q <= 1'b0;
    end
    else
    begin
      pend_q    <= pend_d;
      kind_q    <= kind_d;
      acc_on_q  <= acc_on_d;
      acc_bit_q <= acc_bit_d;
    end
  end

  assign accel_en    = acc_on_q && acc_bit_q; // R10
  assign req_pending = pend_q;
  assign req_kind    = kind_q;

  // ****************************************************************
  // register access and owed status
  // ****************************************************************
  logic [3:0] flags_q, flags_d;
  logic       owe_q, owe_d;
  logic       rdp_q, rdp_d;
  logic [3:0] raddr_q, raddr_d;
  logic [7:0] rdat_q, rdat_d;
  logic [3:0] flag_sent;
  logic       reg_sent;
  logic       irq_set;

  always_comb
  begin
    flags_d = flags_q & ~flag_sent; // R20
    // a new event wins over the delivery clear
    if (arb_reset_gap)
      flags_d[FLG_ARB_GAP] = 1'b1; // R22
    if (subaction_gap)
      flags_d[FLG_SUB_GAP] = 1'b1; // R22
    if (bus_reset)
      flags_d[FLG_BUS_RST] = 1'b1; // R22
    if (core_irq || irq_set)
      flags_d[FLG_IRQ] = 1'b1; // R22
    owe_d   = owe_q && !reg_sent; // R20
    rdp_d   = 1'b0;
    raddr_d = raddr_q;
    rdat_d  = rdp_q ? rm.rdata : rdat_q;
    if (!owe_q) // R9
    begin
      if (self_id_done)
      begin
        owe_d   = 1'b1; // R19
        rdp_d   = 1'b1;
        raddr_d = REG_NODE_ID;
      end
      else if (req.valid && req.kind == REQ_RD)
      begin
        owe_d   = 1'b1; // R8
        rdp_d   = 1'b1;
        raddr_d = req.addr;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_q <= 4'h0;
      owe_q   <= 1'b0;
      rdp_q   <= 1'b0;
      raddr_q <= 4'h0;
      rdat_q  <= 8'h00;
    end
    else
    begin
      flags_q <= flags_d;
      owe_q   <= owe_d;
      rdp_q   <= rdp_d;
      raddr_q <= raddr_d;
      rdat_q  <= rdat_d;
    end
  end

  assign rm.we    = req.valid && req.kind == REQ_WR; // R7
  assign rm.waddr = req.addr;
  assign rm.wdata = req.data;
  assign rm.raddr = raddr_d;

  // ****************************************************************
  // interface line sequencer
  // ****************************************************************
  line_state_t st_q, st_d;
  logic [1:0]  lo_q, lo_d;
  logic [1:0]  dat_q, dat_d;
  logic [4:0]  idx_q, idx_d;
  logic        full_q, full_d;
  logic        stat_en_q;
  logic [15:0] frame;

  always_comb
  begin
    frame     = {rdat_q, raddr_q, flags_q};
    st_d      = st_q;
    lo_d      = LINE_IDLE;
    dat_d     = 2'h0;
    idx_d     = idx_q;
    full_d    = full_q;
    flag_sent = 4'h0;
    reg_sent  = 1'b0;
    grant_go  = 1'b0;
    if (pkt_rx && st_q != s_grant && st_q != s_link)
    begin
      st_d = s_recv; // R16
      lo_d = LINE_RECV;
    end
    else
      unique case (st_q)
        s_recv:
          if (pend_q && kind_q == REQ_IMM)
          begin
            grant_go = 1'b1; // R2
            st_d     = s_grant;
            lo_d     = LINE_GRANT;
          end
          else
            st_d = s_idle;
        s_grant:
          st_d = s_link;
        s_link:
          if (interface_control_lines_in == LINE_IDLE)
            st_d = s_idle;
        s_stat:
          if (idx_q > (full_q ? IDX_FULL_LAST : IDX_FLAGS_LAST))
            st_d = s_idle; // R17
          else
          begin
            lo_d  = LINE_STAT; // R15
            dat_d = pick2(frame, idx_q); // R26
            idx_d = idx_q + IDX_STEP;
            if (idx_q == IDX_FLAGS_LAST)
              flag_sent[3:2] = 2'h3; // R20
            if (idx_q == IDX_FULL_LAST)
              reg_sent = 1'b1; // R20
          end
        s_idle:
          if (arb_won && pend_q)
          begin
            grant_go = 1'b1;
            st_d     = s_grant;
            lo_d     = LINE_GRANT;
          end
          else if (stat_en_q && !rdp_q && (owe_q || flags_q != 4'h0))
          begin
            st_d           = s_stat; // R14 R21
            lo_d           = LINE_STAT; // R15
            dat_d          = pick2(frame, 5'h00); // R26
            idx_d          = IDX_STEP;
            full_d         = owe_q; // R18
            flag_sent[1:0] = 2'h3; // R20
          end
      endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= s_idle;
      lo_q   <= LINE_IDLE;
      dat_q  <= 2'h0;
      idx_q  <= 5'h00;
      full_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      lo_q   <= lo_d;
      dat_q  <= dat_d;
      idx_q  <= idx_d;
      full_q <= full_d;
    end
  end

  // the link owns both line groups after a grant
  assign interface_control_lines_out  = lo_q;
  assign interface_control_lines_oe_n = st_q == s_link;
  assign data_out                     = dat_q;
  assign data_oe_n                    = st_q == s_link;

  // ****************************************************************
  // avalon slave, one wait state
  // ****************************************************************
  logic        ack_q, ack_d;
  logic        stat_en_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb
  begin
    ack_d     = (read || write) && !ack_q;
    stat_en_d = stat_en_q;
    rdata_d   = rdata_q;
    irq_set   = 1'b0;
    if (read && !ack_q)
    begin
      rdata_d = 32'h0000_0000;
      if (address == OFS_STATUS)
        rdata_d[9:0] = {accel_en, kind_q, pend_q, owe_q, flags_q};
      if (address == OFS_CTRL)
        rdata_d[CTRL_STAT_EN] = stat_en_q;
    end
    if (write && ack_q && address == OFS_CTRL)
    begin
      stat_en_d = writedata[CTRL_STAT_EN];
      irq_set   = writedata[CTRL_IRQ_SET];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_q     <= 1'b0;
      stat_en_q <= STAT_EN_RST;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ack_q     <= ack_d;
      stat_en_q <= stat_en_d;
      rdata_q   <= rdata_d;
    end
  end

  assign waitrequest = (read || write) && !ack_q;
  assign readdata    = rdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  imm_grant_a: // R2
    assert property (st_q == s_recv && !pkt_rx && pend_q &&
      kind_q == REQ_IMM |=> lo_q == LINE_GRANT ##1 st_q == s_link)
    else $error("immediate request not granted at packet end");

  busy_ignore_a: // R5
    assert property (pend_q && !grant_go && !bus_reset && !pkt_rx
      |=> pend_q && kind_q == $past(kind_q))
    else $error("pending bus request disturbed");

  reset_clear_a: // R6
    assert property (bus_reset |=> !pend_q)
    else $error("bus reset left a request pending");

  reg_write_a: // R7
    assert property (req.valid && req.kind == REQ_WR
      |=> u_mem.mem_q[$past(req.addr)] == $past(req.data))
    else $error("register write not stored");

  read_keep_a: // R9
    assert property (owe_q && !reg_sent |=> owe_q &&
      raddr_q == $past(raddr_q))
    else $error("owed register dropped or replaced");

  accel_req_a: // R11
    assert property (req.valid && req.kind == REQ_ACC && !bus_reset
      |=> acc_on_q == $past(req.accel_on))
    else $error("acceleration request not applied");

  accel_reen_a: // R12
    assert property (bus_reset && acc_bit_q && !req.valid |=> accel_en)
    else $error("acceleration not re-enabled by bus reset");

  flag_len_a: // R18
    assert property ($rose(lo_q == LINE_STAT) && !full_q && !pkt_rx
      ##1 !pkt_rx |=> lo_q == LINE_IDLE)
    else $error("flag transfer not two cycles long");

  full_len_a: // R18
    assert property ($rose(lo_q == LINE_STAT) && full_q ##0
      (!pkt_rx)[*8] |=> lo_q == LINE_IDLE && !$past(owe_q))
    else $error("register transfer not eight cycles long");

  flag_done_a: // R20
    assert property ($rose(lo_q == LINE_STAT) && !$past(arb_reset_gap)
      && !$past(subaction_gap) |-> flags_q[1:0] == 2'h0)
    else $error("driven flags not marked delivered");

  first_bits_a: // R26
    assert property ($rose(lo_q == LINE_STAT)
      |-> data_out == $past(frame[1:0]) && $past(st_q) == s_idle)
    else $error("status did not start with bits 0 and 1");

  cut_retry_a: // R16
    assert property (st_q == s_stat && pkt_rx && owe_q
      |=> lo_q == LINE_RECV && owe_q)
    else $error("interrupted register transfer not kept owed");

  imm_grant_c: cover property (st_q == s_recv ##1 st_q == s_grant);
  full_stat_c: cover property (reg_sent);
  cut_stat_c:  cover property (st_q == s_stat && pkt_rx);
  accel_off_c: cover property (req.valid && req.kind == REQ_ACC &&
                               !req.accel_on);

endmodule
`default_nettype wire

// *** link_request_status_interface_tb_top.sv ***
`default_nettype none
module link_request_status_interface_tb_top import lrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        pkt_rx = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        req_line;
  logic [1:0]  lines_in;
  logic [1:0]  lines_out;
  logic        oe_n;
  logic        doe_n;
  logic [1:0]  dout;
  logic        req_pending;
  logic [2:0]  req_kind;
  logic        accel_en;
  int          num_errors;
  int          n_compared;
  int          seed = 73;
  int          base;
  logic [31:0] rv;
  logic [3:0]  a;
  logic [7:0]  d;

  always #4 clk = ~clk;

  link_phy_port dut (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .link_request_line(req_line),
    .interface_control_lines_in(lines_in),
    .interface_control_lines_out(lines_out),
    .interface_control_lines_oe_n(oe_n), .data_out(dout),
    .data_oe_n(doe_n), .pkt_rx(pkt_rx), .arb_won(ev[5]),
    .bus_reset(ev[2]), .arb_reset_gap(ev[0]), .subaction_gap(ev[1]),
    .self_id_done(ev[4]), .core_irq(ev[3]), .req_pending(req_pending),
    .req_kind(req_kind), .accel_en(accel_en));

  link_ctrl_model link (
    .clk(clk), .arst_n(arst_n), .req_line(req_line),
    .lines_in(lines_in), .lines_out(lines_out), .lines_oe_n(oe_n),
    .dat(dout));

  // ************
  // helpers
  // ************
  function automatic logic [31:0] pkt(logic [3:0] x, logic [7:0] v,
                                      logic [3:0] f);
    return {16'h0000, v, x, f};
  endfunction
  function automatic logic [16:0] rd_req(logic [3:0] x);
    return {8'h00, 1'b1, REQ_RD, x, 1'b0};
  endfunction
  function automatic logic [16:0] wr_req(logic [3:0] x, logic [7:0] v);
    return {1'b1, REQ_WR, x, v, 1'b0};
  endfunction
  function automatic logic [16:0] bus_req(logic [2:0] k);
    return {10'h000, 1'b1, k, 3'h0};
  endfunction
  function automatic logic [16:0] acc_req(logic e);
    return {11'h000, 1'b1, REQ_ACC, e, 1'b0};
  endfunction

  task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic stall();
    num_errors++;
    give_verdict();
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic av(logic w, logic [3:0] ad, logic [31:0] wd,
                    output logic [31:0] rd);
    int i;
    read      <= !w;
    write     <= w;
    address   <= ad;
    writedata <= wd;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    if (i == 20)
      stall();
  endtask
  task automatic pulse(int b);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    @(posedge clk);
  endtask
  task automatic wait_stat();
    int i;
    for (i = 0; i < 300 && link.ns == base; i++)
      @(posedge clk);
    if (i == 300)
      stall();
  endtask
  task automatic wait_lines(logic [1:0] v, int n);
    int i;
    for (i = 0; i < n && !(lines_out === v && oe_n === 1'b0); i++)
      @(posedge clk);
    if (i == n)
      stall();
  endtask

  // ************
  // scenarios
  // ************
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check("lines reset", 32'(lines_out), 32'(LINE_IDLE));
    av(1'b0, OFS_CTRL, 32'h0, rv);
    check("ctrl reset", rv, 32'h1);
    av(1'b0, 4'h8, 32'h0, rv);
    check("unmapped", rv, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      base = link.ns;
      pulse(k);
      wait_stat();
      check("flag len", 32'(link.nlen), 32'h2);
      check("flags", 32'(link.word), 32'h1 << k);
    end
    for (int n = 0; n < 6; n++)
    begin
      a = (n == 0) ? 4'h1 : {1'b1, 3'($random(seed))};
      d = (n == 0) ? 8'hff : 8'($random(seed));
      link.send(wr_req(a, d), 17);
      repeat (4) @(posedge clk);
      base = link.ns;
      link.send(rd_req(a), 9);
      wait_stat();
      check("full len", 32'(link.nlen), 32'h8);
      check("reg pkt", 32'(link.word), pkt(a, d, 4'h0));
    end
    av(1'b1, OFS_CTRL, 32'h0, rv);
    link.send(rd_req(a), 9);
    link.send(rd_req(4'h1), 9);
    pulse(2);
    base = link.ns;
    av(1'b1, OFS_CTRL, 32'h1, rv);
    wait_stat();
    check("owed reg", 32'(link.word), pkt(a, d, 4'h4));
    base = link.ns;
    repeat (40) @(posedge clk);
    check("no second", 32'(link.ns), 32'(base));
    av(1'b1, OFS_CTRL, 32'h2, rv);
    link.send(rd_req(a), 9);
    base = link.ns;
    av(1'b1, OFS_CTRL, 32'h1, rv);
    wait_lines(LINE_STAT, 60);
    repeat (2) @(posedge clk);
    pkt_rx <= 1'b1;
    wait_stat();
    check("cut flags", 32'(link.word), 32'h8);
    check("recv", 32'(lines_out), 32'(LINE_RECV));
    repeat (5) @(posedge clk);
    base = link.ns;
    pkt_rx <= 1'b0;
    wait_stat();
    check("retry", 32'(link.word), pkt(a, d, 4'h0));
    for (int k = 1; k < 4; k++)
    begin
      link.send(bus_req(3'(k)), 7);
      repeat (3) @(posedge clk);
      link.send(bus_req(REQ_IMM), 7);
      repeat (3) @(posedge clk);
      av(1'b0, OFS_STATUS, 32'h0, rv);
      check("pending", 32'(rv[8:5]), 32'({3'(k), 1'b1}));
      pulse(2);
      check("cleared", 32'(req_pending), 32'h0);
    end
    pkt_rx <= 1'b1;
    link.hold = 1;
    link.send(bus_req(REQ_IMM), 7);
    repeat (3) @(posedge clk);
    check("imm", 32'({req_pending, req_kind}), 32'h8);
    pkt_rx <= 1'b0;
    wait_lines(LINE_GRANT, 4);
    wait_lines(LINE_IDLE, 20);
    link.hold = 6;
    link.send(bus_req(REQ_FAIR), 7);
    repeat (2) @(posedge clk);
    pulse(5);
    wait_lines(LINE_GRANT, 4);
    @(posedge clk);
    check("data oe", 32'(doe_n), 32'h1);
    wait_lines(LINE_IDLE, 20);
    check("won", 32'(req_pending), 32'h0);
    link.send(wr_req(REG_ACCEL, 8'h01), 17);
    repeat (4) @(posedge clk);
    check("accel reg", 32'(accel_en), 32'h1);
    link.send(acc_req(1'b0), 6);
    repeat (4) @(posedge clk);
    check("accel off", 32'(accel_en), 32'h0);
    link.send(bus_req(REQ_ISO), 7);
    repeat (4) @(posedge clk);
    check("iso on", 32'(accel_en), 32'h1);
    pulse(2);
    link.send(acc_req(1'b0), 6);
    repeat (4) @(posedge clk);
    pulse(2);
    check("reset on", 32'(accel_en), 32'h1);
    link.send(wr_req(REG_ACCEL, 8'h00), 17);
    link.send(bus_req(REQ_ISO), 7);
    repeat (4) @(posedge clk);
    check("bit clear", 32'(accel_en), 32'h0);
    pulse(2);
    link.send(wr_req(REG_NODE_ID, d), 17);
    repeat (20) @(posedge clk);
    base = link.ns;
    pulse(4);
    wait_stat();
    check("node id", 32'(link.word[15:4]), 32'({d, REG_NODE_ID}));
    give_verdict();
  end
endmodule
`default_nettype wire

// *** lrs_if.sv ***
`default_nettype none
// decoded request from the serial receiver
interface req_if;
  logic       valid;
  logic [2:0] kind;
  logic [3:0] addr;
  logic [7:0] data;
  logic       accel_on;
  modport src (output valid, kind, addr, data, accel_on);
  modport dst (input valid, kind, addr, data, accel_on);
endinterface

// register file access
interface regmem_if;
  logic       we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport mem (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface
`default_nettype wire

// *** lrs_pkg.sv ***
`default_nettype none
package lrs_pkg;

  // ****************************************************************
  // link request type codes, first bit on the line is the msb
  // ****************************************************************
  localparam logic [2:0] REQ_IMM  = 3'h0;
  localparam logic [2:0] REQ_ISO  = 3'h1;
  localparam logic [2:0] REQ_PRI  = 3'h2;
  localparam logic [2:0] REQ_FAIR = 3'h3;
  localparam logic [2:0] REQ_RD   = 3'h4;
  localparam logic [2:0] REQ_WR   = 3'h5;
  localparam logic [2:0] REQ_ACC  = 3'h6;
  localparam logic [2:0] REQ_RSV  = 3'h7;

  // bits after the start bit, stop bit included except in LEN_TYPE, which counts the type bits only
  localparam logic [4:0] LEN_TYPE  = 5'h03;
  localparam logic [4:0] LEN_BUS_S = 5'h06;
  localparam logic [4:0] LEN_BUS_L = 5'h07;
  localparam logic [4:0] LEN_RD    = 5'h08;
  localparam logic [4:0] LEN_WR    = 5'h10;
  localparam logic [4:0] LEN_ACC   = 5'h05;
  localparam logic [4:0] LEN_RSV   = 5'h04;

  // ****************************************************************
  // control line codes and status packet
  // ****************************************************************
  localparam logic [1:0] LINE_IDLE  = 2'h0;
  localparam logic [1:0] LINE_STAT  = 2'h1;
  localparam logic [1:0] LINE_RECV  = 2'h2;
  localparam logic [1:0] LINE_GRANT = 2'h3;
  localparam int         FLG_ARB_GAP = 0;
  localparam int         FLG_SUB_GAP = 1;
  localparam int         FLG_BUS_RST = 2;
  localparam int         FLG_IRQ     = 3;
  localparam logic [4:0] IDX_STEP       = 5'h02;
  localparam logic [4:0] IDX_FLAGS_LAST = 5'h02;
  localparam logic [4:0] IDX_FULL_LAST  = 5'h0e;

  // ****************************************************************
  // register file and avalon map
  // ****************************************************************
  localparam logic [3:0] REG_NODE_ID   = 4'h0;
  localparam logic [3:0] REG_ACCEL     = 4'h5;
  localparam int         ACCEL_EN_BIT  = 0;
  localparam logic [3:0] OFS_STATUS    = 4'h0;
  localparam logic [3:0] OFS_CTRL      = 4'h4;
  localparam int         CTRL_STAT_EN  = 0;
  localparam int         CTRL_IRQ_SET  = 1;
  localparam logic       STAT_EN_RST   = 1'b1;

  function automatic logic is_bus(input logic [2:0] kind);
    return !kind[2];
  endfunction

  function automatic logic is_async(input logic [2:0] kind);
    return kind == REQ_FAIR || kind == REQ_PRI;
  endfunction

endpackage
`default_nettype wire

// *** reg_mem.sv ***
`default_nettype none
module reg_mem (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // access port
  regmem_if.mem     port
);

  logic [7:0] mem_q [16];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 16; i++)
        mem_q[i] <= 8'h00;
      port.rdata <= 8'h00;
    end
    else
    begin
      if (port.we)
        mem_q[port.waddr] <= port.wdata;
      port.rdata <= mem_q[port.raddr];
    end
  end

endmodule
`default_nettype wire

// *** req_rx.sv ***
`default_nettype none
module req_rx
  import lrs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // serial line from the link
  input  wire logic link_request_line,
  // decoded request, one cycle pulse
  req_if.src        req
);

  logic        busy_q, busy_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic        vld_q, vld_d;
  logic [2:0]  kind_q, kind_d;
  logic [3:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic        acc_q, acc_d;

  function automatic logic [4:0] req_len(input logic [2:0] k,
                                         input logic b6);
    unique case (k)
      REQ_RD:  return LEN_RD;
      REQ_WR:  return LEN_WR;
      REQ_ACC: return LEN_ACC;
      REQ_RSV: return LEN_RSV;
      default: return b6 ? LEN_BUS_L : LEN_BUS_S;
    endcase
  endfunction

  always_comb
  begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    vld_d  = 1'b0;
    kind_d = kind_q;
    addr_d = addr_q;
    data_d = data_q;
    acc_d  = acc_q;
    if (!busy_q)
    begin
      busy_d = link_request_line;
      cnt_d  = 5'h00;
      sh_d   = 16'h0000;
    end
    else
    begin
      sh_d  = {sh_q[14:0], link_request_line};
      cnt_d = cnt_q + 5'h01;
      if (cnt_d == LEN_TYPE)
        kind_d = sh_d[2:0];
      if (cnt_d > LEN_TYPE && (cnt_d == req_len(kind_q, sh_d[0]) ||
          (is_bus(kind_q) && cnt_d == LEN_BUS_L)))
      begin
        busy_d = 1'b0;
        vld_d  = kind_q != REQ_RSV;
        addr_d = kind_q == REQ_WR ? sh_d[12:9] : sh_d[4:1]; // R23 R24
        data_d = sh_d[8:1]; // R24
        acc_d  = sh_d[1]; // R25
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 5'h00;
      sh_q   <= 16'h0000;
      vld_q  <= 1'b0;
      kind_q <= 3'h0;
      addr_q <= 4'h0;
      data_q <= 8'h00;
      acc_q  <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      vld_q  <= vld_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      data_q <= data_d;
      acc_q  <= acc_d;
    end
  end

  assign req.valid    = vld_q;
  assign req.kind     = kind_q;
  assign req.addr     = addr_q;
  assign req.data     = data_q;
  assign req.accel_on = acc_q;

endmodule
`default_nettype wire
